/* File: rtl/eepc_host.sv */
// Purpose: Host that writes bytes and pages to a parallel EEPROM and waits
//          for internal write completion by polling or by full timeout.
// Assumes: Device pins are synchronous to clk_in.
// Notes:   One request at a time; req_ready_out shows the port is free.
`timescale 1ns/10ps
`default_nettype none
module eepc_host
    import eepc_pkg::*;
#(
    parameter int WRITE_CYC = INTERNAL_WRITE_CYC,   // Full write wait
    parameter int POST_CYC = POST_POLL_CYC,         // Post-poll gap
    parameter bit USE_POLL = 1'b1                   // Poll, else time out
) (
    input wire logic clk_in,                        // 20 MHz clock
    input wire logic nrst_in,                       // Async reset, low
    input wire logic ce_in,                         // Clock enable
    input wire logic req_valid_in,                  // Request offered
    input wire eepc_pkg::eepc_req_t req_in,         // Request fields
    output logic req_ready_out,                     // Ready for request
    output logic rd_valid_out,                      // Read data pulse
    output logic [eepc_pkg::DATA_W-1:0] rd_data_out, // Read data
    output logic write_busy_out,                    // Internal write pending
    output var eepc_pkg::eepc_strobe_t strobe_out,  // Chip, output, write
    output logic [eepc_pkg::ADDR_W-1:0] addr_out,   // Address pins
    output logic [eepc_pkg::DATA_W-1:0] dq_out,     // Data pins out
    output logic dq_oe_out,                         // Host drives data
    input wire logic [eepc_pkg::DATA_W-1:0] dq_in   // Data pins in
);
    import eepc_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_WSETUP, ST_WPULSE, ST_WREC, ST_RSETUP, ST_RWAIT,
        ST_RDONE, ST_WAIT_FULL, ST_POLL, ST_POLL_WAIT, ST_GAP
    } eepc_state_t;

    eepc_state_t state;
    logic tmr_load;
    logic [CNT_W-1:0] tmr_val;
    logic tmr_done;
    logic [DATA_W-1:0] last_data;
    logic poll_mode;

    // ======================================================
    // Shared timer
    // ======================================================
    eepc_timer #(.W(CNT_W)) u_timer (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .en_in(ce_in),
        .load_in(tmr_load),
        .value_in(tmr_val),
        .done_out(tmr_done)
    );

    // Decode of a completed poll; bit 7 matches written data
    function automatic logic poll_true(input logic [DATA_W-1:0] rd,
                                       input logic [DATA_W-1:0] wr);
        poll_true = (rd[POLL_BIT] == wr[POLL_BIT]);
    endfunction : poll_true

    // ======================================================
    // Sequencer
    // ======================================================
    // Timer loads in the same cycle the state moves
    always_comb begin
        tmr_load = 1'b0;
        tmr_val = '0;
        case (state)
            ST_IDLE: begin
                if (req_valid_in) begin
                    tmr_load = 1'b1;
                    // A poll-only request skips the byte load entirely
                    if (req_in.cmd != EEPC_CMD_POLL_END) begin
                        tmr_val = CNT_W'(STROBE_CYC);
                    end else begin
                        tmr_val = USE_POLL ? CNT_W'(READ_CYC)
                                           : CNT_W'(WRITE_CYC);
                    end
                end
            end
            ST_WSETUP, ST_WPULSE, ST_RSETUP: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_val = (state == ST_RSETUP) ? CNT_W'(READ_CYC)
                                                   : CNT_W'(STROBE_CYC);
                end
            end
            ST_WREC: begin
                if (tmr_done && poll_mode) begin
                    tmr_load = 1'b1;
                    tmr_val = USE_POLL ? CNT_W'(READ_CYC)
                                       : CNT_W'(WRITE_CYC);
                end
            end
            ST_POLL_WAIT: begin
                if (tmr_done) begin
                    tmr_load = 1'b1;
                    tmr_val = poll_true(dq_in, last_data)
                        ? CNT_W'(POST_CYC) : CNT_W'(READ_CYC);
                end
            end
            default: begin
                tmr_load = 1'b0;
                tmr_val = '0;
            end
        endcase
    end

    // State transitions
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state <= ST_IDLE;
        end else if (ce_in) begin
            case (state)
                ST_IDLE: begin
                    if (req_valid_in) begin
                        case (req_in.cmd)
                            EEPC_CMD_READ: state <= ST_RSETUP;
                            EEPC_CMD_POLL_END: begin
                                state <= USE_POLL ? ST_POLL : ST_WAIT_FULL;
                            end
                            default: state <= ST_WSETUP;
                        endcase
                    end
                end
                ST_WSETUP: if (tmr_done) state <= ST_WPULSE;
                ST_WPULSE: if (tmr_done) state <= ST_WREC;
                ST_WREC: begin
                    if (tmr_done) begin
                        if (!poll_mode) begin
                            state <= ST_IDLE;     // More page bytes follow
                        end else begin
                            state <= USE_POLL ? ST_POLL : ST_WAIT_FULL;
                        end
                    end
                end
                ST_RSETUP: if (tmr_done) state <= ST_RWAIT;
                ST_RWAIT: if (tmr_done) state <= ST_RDONE;
                ST_RDONE: state <= ST_IDLE;
                ST_WAIT_FULL: if (tmr_done) state <= ST_IDLE;
                ST_POLL: state <= ST_POLL_WAIT;
                ST_POLL_WAIT: begin
                    if (tmr_done) begin
                        // Poll repeats until the top bit reads true
                        state <= poll_true(dq_in, last_data)
                            ? ST_GAP : ST_POLL;
                    end
                end
                ST_GAP: if (tmr_done) state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Captured write byte and whether this load ends the page
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            last_data <= '0;
            poll_mode <= 1'b0;
        end else if (ce_in && state == ST_IDLE && req_valid_in
                     && req_in.cmd != EEPC_CMD_READ
                     && req_in.cmd != EEPC_CMD_POLL_END) begin
            // Poll-only requests keep the byte that the poll compares to
            last_data <= req_in.data;
            poll_mode <= req_in.last;
        end
    end

    // ======================================================
    // Pins
    // ======================================================
    // Write: ce low, oe high, we pulsed; read/poll: ce, oe low, we high
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            strobe_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
            dq_oe_out <= 1'b0;
            addr_out <= '0;
            dq_out <= '0;
        end else if (ce_in) begin
            // A poll stays on the address of the last write or read request
            if (state == ST_IDLE && req_valid_in
                && req_in.cmd != EEPC_CMD_POLL_END) begin
                addr_out <= req_in.addr;
                dq_out <= req_in.data;
            end
            case (state)
                ST_WSETUP: begin
                    strobe_out <= '{ce_n: 1'b0, oe_n: 1'b1,
                                    we_n: !tmr_done};
                    dq_oe_out <= 1'b1;
                end
                ST_WPULSE: begin
                    strobe_out <= '{ce_n: 1'b0, oe_n: 1'b1,
                                    we_n: tmr_done};
                    dq_oe_out <= 1'b1;
                end
                ST_RSETUP, ST_RWAIT, ST_POLL, ST_POLL_WAIT: begin
                    // Poll keeps ce low and we high between loads
                    strobe_out <= '{ce_n: 1'b0, oe_n: 1'b0,
                                    we_n: 1'b1};
                    dq_oe_out <= 1'b0;
                end
                default: begin
                    strobe_out <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
                    dq_oe_out <= 1'b0;
                end
            endcase
        end
    end

    // Read result and status
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out <= '0;
            req_ready_out <= 1'b0;
            write_busy_out <= 1'b0;
        end else if (ce_in) begin
            rd_valid_out <= (state == ST_RWAIT) && tmr_done;
            if (state == ST_RWAIT && tmr_done) begin
                rd_data_out <= dq_in;
            end
            req_ready_out <= (state == ST_IDLE) && !req_valid_in;
            write_busy_out <= (state == ST_WAIT_FULL) || (state == ST_POLL)
                || (state == ST_POLL_WAIT) || (state == ST_GAP);
        end
    end

    // ======================================================
    // Checks
    // ======================================================
    a_strobe_legal: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !(strobe_out.we_n == 1'b0 && strobe_out.oe_n == 1'b0))
        else $error("write and output enable low together");
    a_write_ce_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $fell(strobe_out.we_n) |-> !strobe_out.ce_n)
        else $error("write pulse without chip enable");
    a_we_width: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $fell(strobe_out.we_n) |-> (!strobe_out.we_n)[*2])
        else $error("write pulse too short");
    a_data_driven: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !strobe_out.we_n |-> dq_oe_out)
        else $error("data not driven during write");
    a_poll_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (state == ST_POLL_WAIT) |-> (!strobe_out.oe_n && strobe_out.we_n &&
        !dq_oe_out))
        else $error("poll is not a read cycle");
    a_gap_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (state == ST_GAP) |=> strobe_out.we_n)
        else $error("write during post-poll gap");
    a_full_wait: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (state == ST_WAIT_FULL) |=> strobe_out.ce_n)
        else $error("access during write time");
    a_busy_flag: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (ce_in && state == ST_GAP) |=> write_busy_out)
        else $error("busy flag dropped early");
    c_write: cover property (@(posedge clk_in) $rose(strobe_out.we_n));
    c_poll_done: cover property (@(posedge clk_in) state == ST_GAP);
    c_read: cover property (@(posedge clk_in) rd_valid_out);
    c_poll_end: cover property (@(posedge clk_in) state == ST_IDLE &&
        req_valid_in && req_in.cmd == EEPC_CMD_POLL_END);
endmodule : eepc_host
`default_nettype wire

/* File: rtl/eepc_pkg.sv */
// Purpose: Shared constants and types for the EEPROM write and poll host.
// Assumes: 20 MHz clock, parallel byte-wide EEPROM with active-low strobes.
// Notes:   Times are kept in their own units; cycle counts derive from them.
package eepc_pkg;
    // ======================================================
    // Clock and timing
    // ======================================================
    localparam int CLK_MHZ = 20;
    localparam int WRITE_TIME_MS = 5;          // Longest internal write
    localparam int WRITE_TYP_MS = 3;           // Typical internal write
    localparam int POST_POLL_US = 10;          // Gap after poll is true
    localparam int STROBE_NS = 50;             // Strobe and setup least time
    localparam int CLK_NS = 1000 / CLK_MHZ;
    localparam int INTERNAL_WRITE_CYC = WRITE_TIME_MS * 1000 * CLK_MHZ;
    localparam int POST_POLL_CYC = POST_POLL_US * CLK_MHZ;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int READ_NS = 150;              // Slowest read access
    localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 24;
    // ======================================================
    // Widths and types
    // ======================================================
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int TOGGLE_BIT = 6;             // toggle_bit_line position
    localparam int POLL_BIT = 7;               // Complemented while busy

    typedef enum logic [1:0] {
        EEPC_CMD_WRITE = 2'h0,
        EEPC_CMD_READ = 2'h1,
        EEPC_CMD_POLL_END = 2'h2
    } eepc_cmd_t;

    typedef struct packed {
        eepc_cmd_t cmd;
        logic last;                            // Last byte of a page
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } eepc_req_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
    } eepc_strobe_t;
endpackage : eepc_pkg

/* File: rtl/eepc_timer.sv */
// Purpose: Down counter for strobe widths and write waits.
// Assumes: Load and count only while enabled.
// Notes:   done_out is high while the count is zero.
`timescale 1ns/10ps
`default_nettype none
module eepc_timer #(
    parameter int W = 24
) (
    input wire logic clk_in,               // System clock
    input wire logic nrst_in,              // Async reset, low
    input wire logic en_in,                // Clock enable
    input wire logic load_in,              // Load a new count
    input wire logic [W-1:0] value_in,     // Count to load
    output logic done_out                  // Count reached zero
);
    logic [W-1:0] cnt;

    // ======================================================
    // Counter
    // ======================================================
    // Load wins over the running count
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt <= '0;
        end else if (en_in) begin
            if (load_in) begin
                cnt <= value_in;
            end else if (cnt != '0) begin
                cnt <= cnt - 1'b1;
            end
        end
    end

    assign done_out = (cnt == '0);
endmodule : eepc_timer
`default_nettype wire

/* File: sim/eepc_dev_model.sv */
// Purpose: Behavioural byte-wide EEPROM seen by the host under test.
// Assumes: Strobes and data are sampled on clk_in; busy length in cycles.
// Notes:   Counts host timing faults on viol_out instead of stopping.
`timescale 1ns/10ps
`default_nettype none
module eepc_dev_model
    import eepc_pkg::*;
#(
    parameter int POST = 10,                          // Least post-poll gap
    parameter int WIN = 20                            // Page load window
) (
    input wire logic clk_in,                          // Bench clock
    input wire logic [15:0] busy_cyc_in,              // Internal write length
    input wire eepc_pkg::eepc_strobe_t strobe_in,     // Host strobes
    input wire logic [eepc_pkg::ADDR_W-1:0] addr_in,  // Address pins
    input wire logic [eepc_pkg::DATA_W-1:0] din_in,   // Host data
    output logic [eepc_pkg::DATA_W-1:0] dq_out,       // Device data
    output logic [7:0] viol_out                       // Host faults seen
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] last_byte = 8'h00;
    logic [DATA_W-1:0] drv = 8'h00;
    logic [ADDR_W-1:0] pend_addr = '0;
    logic [15:0] busy = 16'h0000;
    logic [7:0] viol = 8'h00;
    eepc_strobe_t prev = '1;
    int since_load = 1000;
    int since_done = 1000;
    logic tog = 1'b0;
    logic rd;
    logic wr;
    logic rise;
    // ==================================================
    // Mode decode
    // ==================================================
    assign rd = !strobe_in.ce_n && !strobe_in.oe_n && strobe_in.we_n;
    assign wr = !strobe_in.ce_n && strobe_in.oe_n && !strobe_in.we_n;
    assign viol_out = viol;
    // End of a byte load; restarts the self-timed write
    assign rise = !prev.we_n && strobe_in.we_n && !prev.ce_n;
    // Released bus shows a changing pattern, never the last value
    always_comb begin
        if (rd) begin
            dq_out = (busy != 16'h0000) ?
                {~last_byte[7], tog, last_byte[5:0]} : mem[addr_in];
        end else begin
            dq_out = ~drv;
        end
    end
    // Byte capture, self-timed write and host fault watch
    always_ff @(posedge clk_in) begin
        prev <= strobe_in;
        drv <= dq_out;
        if (since_load < 1000) since_load <= since_load + 1;
        if (since_done < 1000) since_done <= since_done + 1;
        if (busy != 16'h0000) busy <= busy - 16'h0001;
        // A page load that restarts the write is not a completion
        if (busy == 16'h0001 && !rise) since_done <= 0;
        if (wr) begin
            pend_addr <= addr_in;
            last_byte <= din_in;
        end
        if (wr && prev.we_n) begin
            // Late load after page closed, or too soon after polling
            if ((busy != 16'h0000 && since_load > WIN) || since_done < POST) begin
                viol <= viol + 8'h01;
            end
        end
        if (rise) begin
            mem[pend_addr] <= last_byte;
            busy <= busy_cyc_in;
            since_load <= 0;
        end
        if (rd && !(!prev.ce_n && !prev.oe_n) && busy != 16'h0000) begin
            tog <= ~tog;
        end
    end
endmodule : eepc_dev_model
`default_nettype wire

/* File: sim/testbench.sv */
// Purpose: Self-checking bench for the EEPROM write and poll host.
// Assumes: Shortened write and post-poll waits via host parameters.
// Notes:   Device busy length is varied to exercise prompt and slow parts.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import eepc_pkg::*;
    localparam int WCYC = 80;
    localparam int PCYC = 10;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic ce_in = 1'b1;
    logic req_valid = 1'b0;
    eepc_req_t req = '0;
    logic req_ready;
    logic rd_valid;
    logic busy_o;
    logic dq_oe;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] dq_o;
    logic [DATA_W-1:0] dev_dq;
    logic [DATA_W-1:0] dq_in;
    logic [ADDR_W-1:0] addr;
    eepc_strobe_t strobe;
    logic [15:0] busy_cyc = 16'h0005;
    logic [7:0] viol;
    int miscompares = 0;
    int num_checks = 0;
    // Shared data wire: host wins while it drives
    assign dq_in = dq_oe ? dq_o : dev_dq;
    eepc_host #(.WRITE_CYC(WCYC), .POST_CYC(PCYC), .USE_POLL(1'b1)) eepc_host_i (
        .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
        .req_valid_in(req_valid), .req_in(req), .req_ready_out(req_ready),
        .rd_valid_out(rd_valid), .rd_data_out(rd_data),
        .write_busy_out(busy_o), .strobe_out(strobe), .addr_out(addr),
        .dq_out(dq_o), .dq_oe_out(dq_oe), .dq_in(dq_in));
    eepc_dev_model #(.POST(PCYC), .WIN(20)) eepc_dev_model_i (
        .clk_in(clk_in), .busy_cyc_in(busy_cyc), .strobe_in(strobe),
        .addr_in(addr), .din_in(dq_o), .dq_out(dev_dq), .viol_out(viol));
    // ==================================================
    // Clock, checks and verdict
    // ==================================================
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report;
        if (miscompares == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    // One request, held until the taking edge
    task automatic send(input eepc_cmd_t c, input logic l,
                        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 3000) begin
            @(posedge clk_in);
            #5 n++;
        end
        req = '{cmd: c, last: l, addr: a, data: d};
        req_valid = 1'b1;
        @(posedge clk_in);
        #5 req_valid = 1'b0;
    endtask : send
    // Wait for the busy flag to rise and fall, return its length
    task automatic wait_done(output int n);
        int k;
        k = 0;
        while (busy_o !== 1'b1 && k < 20) begin
            @(posedge clk_in);
            #5 k++;
        end
        n = 0;
        while (busy_o !== 1'b0 && n < 3000) begin
            @(posedge clk_in);
            #5 n++;
        end
    endtask : wait_done
    // Write one byte or a page end, return busy length in cycles
    task automatic write_wait(input logic [ADDR_W-1:0] a,
                              input logic [DATA_W-1:0] d, output int n);
        send(EEPC_CMD_WRITE, 1'b1, a, d);
        wait_done(n);
    endtask : write_wait
    task automatic read_chk(input logic [ADDR_W-1:0] a,
                            input logic [DATA_W-1:0] exp);
        int k;
        send(EEPC_CMD_READ, 1'b0, a, 8'h00);
        k = 0;
        while (rd_valid !== 1'b1 && k < 40) begin
            @(posedge clk_in);
            #5 k++;
        end
        check("read data", {8'h00, rd_data}, {8'h00, exp});
    endtask : read_chk
    // ==================================================
    // Scenarios
    // ==================================================
    task automatic t_fast_byte;
        int n;
        busy_cyc = 16'h0005;
        write_wait(15'h0123, 8'hA5, n);
        check("poll ends early", {15'h0000, n < WCYC}, 16'h0001);
        check("post gap kept", {15'h0000, n >= PCYC}, 16'h0001);
        read_chk(15'h0123, 8'hA5);
    endtask : t_fast_byte
    task automatic t_slow_byte;
        int n;
        busy_cyc = 16'h003C;
        write_wait(15'h7FFF, 8'h3C, n);
        check("slow wait", {15'h0000, n + 8 >= 60 + PCYC}, 16'h0001);
        read_chk(15'h7FFF, 8'h3C);
    endtask : t_slow_byte
    task automatic t_page;
        int n;
        busy_cyc = 16'h0008;
        send(EEPC_CMD_WRITE, 1'b0, 15'h0200, 8'h81);
        send(EEPC_CMD_WRITE, 1'b0, 15'h0201, 8'h42);
        write_wait(15'h0202, 8'h18, n);
        check("page wait", {15'h0000, n < WCYC}, 16'h0001);
        read_chk(15'h0200, 8'h81);
        read_chk(15'h0201, 8'h42);
        read_chk(15'h0202, 8'h18);
    endtask : t_page
    // Page closed by a poll-only request, which must not load a byte
    task automatic t_poll_end;
        int n;
        busy_cyc = 16'h0008;
        send(EEPC_CMD_WRITE, 1'b0, 15'h0300, 8'h5A);
        send(EEPC_CMD_WRITE, 1'b0, 15'h0301, 8'hC3);
        send(EEPC_CMD_POLL_END, 1'b0, 15'h0300, 8'h00);
        wait_done(n);
        check("poll end wait", {15'h0000, n < WCYC}, 16'h0001);
        check("poll end gap", {15'h0000, n >= PCYC}, 16'h0001);
        read_chk(15'h0300, 8'h5A);
        read_chk(15'h0301, 8'hC3);
    endtask : t_poll_end
    initial begin
        repeat (20000) @(posedge clk_in);
        miscompares++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge clk_in);
        #5 nrst_in = 1'b1;
        t_fast_byte();
        t_page();
        t_poll_end();
        t_slow_byte();
        t_fast_byte();
        check("host faults", {8'h00, viol}, 16'h0000);
        final_report();
    end
endmodule : testbench
`default_nettype wire
